// ==== hdl/adc_seq_pkg.sv ====
package adc_seq_pkg;
  localparam int NCH = 4;
  localparam int DATA_W = 24;
  localparam int CT_W = 16;
  localparam int MEM_AW = 4;

  // mode select field codes and position
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_STBY = 3'h3;
  localparam logic [2:0] MODE_SELF_ZS = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_CH_ZS = 3'h6;
  localparam logic [2:0] MODE_CH_FS = 3'h7;
  localparam int MODE_SEL_LSB = 5;
  localparam int CLK_DIS_BIT = 4;

  // register byte addresses; the mode register index is printed as 38h
  localparam logic [5:0] MODE_IDX = 6'h38;
  localparam logic [7:0] MODE_BASE = {MODE_IDX, 2'h0};
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] ENABLE_OFS = 8'h04;
  localparam logic [7:0] CT_BASE = 8'h10;
  localparam logic [7:0] DATA_BASE = 8'h40;
  localparam logic [7:0] CZS_BASE = 8'h50;
  localparam logic [7:0] CFS_BASE = 8'h60;
  localparam logic [7:0] AZS_OFS = 8'h70;

  // word indices inside the result memory
  localparam logic [1:0] MEM_DATA = 2'h0;
  localparam logic [1:0] MEM_CZS = 2'h1;
  localparam logic [1:0] MEM_CFS = 2'h2;
  localparam logic [MEM_AW-1:0] MEM_AZS = 4'hc;

  // values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [NCH-1:0] ENABLE_RST = 4'h1;
  localparam logic [CT_W-1:0] CT_RST = 16'h0100;
  localparam logic [CT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {idle_st, run_st, stby_st} seq_state_type;
endpackage : adc_seq_pkg

// ==== hdl/result_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// result memory: one write port, one read port with registered data
module result_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [adc_seq_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [adc_seq_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [adc_seq_pkg::MEM_AW-1:0] rd_addr,
  output logic [adc_seq_pkg::DATA_W-1:0] rd_data
);
  import adc_seq_pkg::*;

  logic [DATA_W-1:0] mem_r [2**MEM_AW];

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // read data leaves from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule : result_mem
`default_nettype wire

// ==== hdl/adc_mode_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// operating-mode sequencer with an apb register slave
module adc_mode_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [adc_seq_pkg::DATA_W-1:0] conv_result,
  output logic ready_n,
  output logic core_power_down,
  output logic buffer_power_down,
  output logic inputs_shorted,
  output logic conv_active,
  output logic [1:0] conv_channel,
  output logic master_clock_output_pin_en
);
  import adc_seq_pkg::*;

  seq_state_type st_r;
  logic [7:0] mode_r;
  logic [1:0] chan_r;
  logic [CT_W-1:0] cnt_r;
  logic [NCH-1:0] flags_r;
  logic [NCH-1:0] flags_nxt;
  logic [NCH-1:0] en_r;
  logic [CT_W-1:0] ct_r [NCH];
  logic [DATA_W-1:0] res_s1_r;
  logic [DATA_W-1:0] res_s2_r;

  logic setup_ph;
  logic fire;
  logic wr_fire;
  logic rd_fire;
  logic mode_hit;
  logic mode_wr;
  logic mem_hit;
  logic data_rd;
  logic reg_hit;
  logic [31:0] reg_rdata;
  logic [2:0] mode_sel;
  logic [2:0] new_sel;
  logic [1:0] new_chan;
  logic done;
  logic [1:0] nxt_chan;
  logic blocked;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_rdata;

  // next enabled channel after cur, circular; stays on cur if no other
  function automatic logic [1:0] next_chan(input logic [1:0] cur,
                                           input logic [NCH-1:0] en);
    logic [1:0] c;
    next_chan = cur;
    for (int i = NCH - 1; i >= 1; i--) begin
      c = cur + 2'(i);
      if (en[c]) begin
        next_chan = c;
      end
    end
  endfunction : next_chan

  // conversion time as a count, never below one cycle
  function automatic logic [CT_W-1:0] load_cnt(input logic [CT_W-1:0] ct);
    load_cnt = (ct == '0) ? CNT_ONE : ct;
  endfunction : load_cnt

  // converter result comes from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_s1_r <= '0;
      res_s2_r <= '0;
    end else begin
      res_s1_r <= conv_result;
      res_s2_r <= res_s1_r;
    end
  end

  // apb phases: one wait state; register effects on the completing edge, a data read drops results for its whole access phase
  assign setup_ph = psel && !penable;
  assign fire = psel && penable && pready;
  assign wr_fire = fire && pwrite;
  assign rd_fire = fire && !pwrite;

  // address decode
  assign mode_hit = (paddr[7:4] == MODE_BASE[7:4]) && (paddr[1:0] == 2'h0);
  assign mem_hit = (paddr[7:6] == DATA_BASE[7:6]) && (paddr[1:0] == 2'h0)
                   && ((paddr[5:4] != 2'h3) || (paddr[3:2] == 2'h0));
  assign mode_wr = wr_fire && mode_hit;
  assign data_rd = rd_fire && mem_hit && (paddr[5:4] == MEM_DATA);
  assign new_sel = pwdata[MODE_SEL_LSB +: 3];
  assign new_chan = paddr[3:2];

  // readable registers other than the result memory
  always_comb begin
    reg_hit = 1'b1;
    reg_rdata = '0;
    if (paddr == STATUS_OFS) begin
      reg_rdata = {22'h0, st_r, 2'h0, chan_r, flags_r};
    end else if (paddr == ENABLE_OFS) begin
      reg_rdata = {28'h0, en_r};
    end else if (paddr[7:4] == CT_BASE[7:4] && paddr[1:0] == 2'h0) begin
      reg_rdata = {16'h0, ct_r[paddr[3:2]]};
    end else if (paddr == MODE_BASE) begin
      reg_rdata = {24'h0, mode_r};
    end else begin
      reg_hit = 1'b0;
    end
  end

  // answer one cycle into the access phase; memory data is ready by then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      if (pwrite) begin
        prdata <= '0;
        pslverr <= !(mode_hit || paddr == ENABLE_OFS
                     || (paddr[7:4] == CT_BASE[7:4] && paddr[1:0] == 2'h0));
      end else if (mem_hit) begin
        prdata <= {8'h0, mem_rdata};
        pslverr <= 1'b0;
      end else begin
        prdata <= reg_hit ? reg_rdata : 32'h0;
        pslverr <= !reg_hit;
      end
    end else begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  // software-written channel enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= ENABLE_RST;
    end else if (wr_fire && paddr == ENABLE_OFS) begin
      en_r <= pwdata[NCH-1:0];
    end
  end

  // software-written conversion times, one per channel, in clock cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ct_r[i] <= CT_RST;
      end
    end else if (wr_fire && paddr[7:4] == CT_BASE[7:4] && paddr[1:0] == 2'h0) begin
      ct_r[paddr[3:2]] <= pwdata[CT_W-1:0];
    end
  end

  // decoded select field, completion and the channel that follows
  assign mode_sel = mode_r[MODE_SEL_LSB +: 3];
  assign done = (st_r == run_st) && (cnt_r == CNT_ONE);
  assign nxt_chan = next_chan(chan_r, en_r);
  // a result landing on the data word being read is dropped
  assign blocked = psel && penable && !pwrite && mem_hit
                   && (paddr[5:4] == MEM_DATA) && (paddr[3:2] == chan_r);

  // mode register: host writes it, a finished one-shot operation clears the select field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
    end else if (mode_wr) begin
      mode_r <= pwdata[7:0];
    end else if (done && (mode_sel != MODE_CONT)) begin
      mode_r[MODE_SEL_LSB +: 3] <= MODE_IDLE;
    end
  end

  // sequencer state follows the written select code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= idle_st;
    end else if (mode_wr) begin
      unique case (new_sel)
        MODE_CONT, MODE_SINGLE, MODE_SELF_ZS, MODE_CH_ZS, MODE_CH_FS: begin
          st_r <= run_st;
        end
        MODE_STBY: begin
          st_r <= stby_st;
        end
        MODE_IDLE, MODE_RSVD: begin
          st_r <= idle_st;
        end
      endcase
    end else if (done && (mode_sel != MODE_CONT)) begin
      st_r <= idle_st;
    end
  end

  // channel being worked on: picked by the write, stepped in continuous mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_r <= 2'h0;
    end else if (mode_wr) begin
      chan_r <= new_chan;
    end else if (done && (mode_sel == MODE_CONT)) begin
      chan_r <= nxt_chan;
    end
  end

  // conversion time counter, reloaded for every channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_ONE;
    end else if (mode_wr) begin
      cnt_r <= load_cnt(ct_r[new_chan]);
    end else if (done && (mode_sel == MODE_CONT)) begin
      cnt_r <= load_cnt(ct_r[nxt_chan]);
    end else if ((st_r == run_st) && !done) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  // where a finished operation leaves its result
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = {MEM_DATA, chan_r};
    if (done && !mode_wr) begin
      unique case (mode_sel)
        MODE_CONT, MODE_SINGLE: begin
          mem_we = !blocked;
        end
        MODE_SELF_ZS: begin
          mem_we = 1'b1;
          mem_waddr = MEM_AZS;
        end
        MODE_CH_ZS: begin
          mem_we = 1'b1;
          mem_waddr = {MEM_CZS, chan_r};
        end
        MODE_CH_FS: begin
          mem_we = 1'b1;
          mem_waddr = {MEM_CFS, chan_r};
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // ready flags: mode write clears all, data read clears one, results set
  always_comb begin
    flags_nxt = flags_r;
    if (data_rd) begin
      flags_nxt[paddr[3:2]] = 1'b0;
    end
    if (done && !mode_wr) begin
      if (mode_sel == MODE_CONT || mode_sel == MODE_SINGLE) begin
        if (!blocked) begin
          flags_nxt[chan_r] = 1'b1;
        end
      end else begin
        flags_nxt = '1;
      end
    end
    if (mode_wr) begin
      flags_nxt = '0;
    end
  end

  // ready flag register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ready pin is low while any flag is set, on the same edge as the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_n <= 1'b1;
    end else begin
      ready_n <= ~|flags_nxt;
    end
  end

  // standby powers down the core and the input buffer; the bus keeps working
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_power_down <= 1'b0;
      buffer_power_down <= 1'b0;
    end else begin
      core_power_down <= (st_r == stby_st);
      buffer_power_down <= (st_r == stby_st);
    end
  end

  // operation running, and inputs shorted during self-calibration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inputs_shorted <= 1'b0;
      conv_active <= 1'b0;
    end else begin
      inputs_shorted <= (st_r == run_st) && (mode_sel == MODE_SELF_ZS);
      conv_active <= (st_r == run_st);
    end
  end

  // channel shown to the converter front end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_channel <= 2'h0;
    end else begin
      conv_channel <= chan_r;
    end
  end

  // clock output follows its disable bit in every mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_clock_output_pin_en <= 1'b1;
    end else begin
      master_clock_output_pin_en <= !mode_r[CLK_DIS_BIT];
    end
  end

  // results and calibration words live in the memory
  result_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(res_s2_r),
    .rd_en(setup_ph),
    .rd_addr(paddr[5:2]),
    .rd_data(mem_rdata)
  );
endmodule : adc_mode_sequencer
`default_nettype wire

// ==== testbench/adc_mode_sequencer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_mode_sequencer_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ready_n,
  input wire logic core_power_down,
  input wire logic buffer_power_down,
  input wire logic inputs_shorted,
  input wire logic conv_active,
  input wire logic master_clock_output_pin_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a write completing on the mode register window
  logic mode_wr;
  assign mode_wr = psel && penable && pready && pwrite && (paddr[7:4] == 4'he)
                   && (paddr[1:0] == 2'h0);
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_mode_wr; mode_wr |=> ready_n; endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("ready pin low after mode write");
  property p_pwr; core_power_down |-> buffer_power_down && !inputs_shorted; endproperty
  a_pwr: assert property (p_pwr) else $error("power-down pair split");
  property p_clk;
    $changed(master_clock_output_pin_en) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
  endproperty
  a_clk: assert property (p_clk) else $error("clock pin moved without write");
  property p_fall; $fell(ready_n) |-> $past(conv_active) || $past(conv_active, 2); endproperty
  a_fall: assert property (p_fall) else $error("ready pin fell with no operation");
  property p_short; inputs_shorted |-> conv_active && !core_power_down; endproperty
  a_short: assert property (p_short) else $error("shorted inputs without calibration");
  c_fall: cover property ($fell(ready_n));
  c_stby: cover property (core_power_down);
  c_short: cover property (inputs_shorted);
  c_err: cover property (pslverr);
endmodule : adc_mode_sequencer_checker
`default_nettype wire

// ==== testbench/conv_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module conv_front_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_active,
  input wire logic inputs_shorted,
  input wire logic [1:0] conv_channel,
  output logic [adc_seq_pkg::DATA_W-1:0] conv_result
);
  import adc_seq_pkg::*;
  logic [DATA_W-1:0] idle_r;
  // changing pattern while no operation holds the input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 24'h0;
    end else begin
      idle_r <= idle_r + 24'h13579b;
    end
  end
  // level held stable for a whole operation, zero when shorted
  always_comb begin
    if (inputs_shorted) begin
      conv_result = 24'h0;
    end else if (conv_active) begin
      conv_result = {4'h5, 18'h0, conv_channel};
    end else begin
      conv_result = idle_r;
    end
  end
endmodule : conv_front_model
`default_nettype wire

// ==== testbench/adc_mode_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_mode_sequencer_bench;
  import adc_seq_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ready_n, cpd, bpd, shorted, active;
  logic clk_en, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] conv_result;
  logic [1:0] conv_channel;
  int n_mismatch, total_checks, ct0, ct1, k;
  // reference model: mode byte, ready flags and the queue of expected stored words
  int m_mode, m_flags;
  logic [31:0] m_q[$];
  logic [2:0] codes [3] = '{MODE_SELF_ZS, MODE_CH_ZS, MODE_CH_FS};
  logic [7:0] cal_addr [3] = '{AZS_OFS, CZS_BASE + 8'h04, CFS_BASE + 8'h04};
  adc_mode_sequencer dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_result(conv_result), .ready_n(ready_n), .core_power_down(cpd),
    .buffer_power_down(bpd), .inputs_shorted(shorted), .conv_active(active),
    .conv_channel(conv_channel), .master_clock_output_pin_en(clk_en));
  conv_front_model front_u (.clk(clk), .rst_n(rst_n), .conv_active(active),
    .inputs_shorted(shorted), .conv_channel(conv_channel), .conv_result(conv_result));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // expected stored level of a channel
  function automatic logic [31:0] lvl(input int c);
    return {8'h0, 4'h5, 18'h0, c[1:0]};
  endfunction : lvl
  // model side of a one-shot operation that has run to its end on channel c
  task automatic m_op(input logic [2:0] code, input int c);
    m_mode = 0;
    if (code == MODE_SINGLE) begin
      m_flags = 1 << c;
      m_q.push_back(lvl(c));
    end else begin
      m_flags = 'hf;
      m_q.push_back((code == MODE_SELF_ZS) ? 32'h0 : lvl(c));
    end
  endtask : m_op
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic hang();
    n_mismatch++;
    $display("ERROR %0t: wait ran out", $time);
    final_report();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (ready_n === 1'b0) break;
    end
    if (i == 4000) hang();
  endtask : wait_rdy
  task automatic wait_ch(input logic [1:0] c, output int n);
    for (n = 0; n < 4000; n++) begin
      @(posedge clk);
      if (conv_channel === c) break;
    end
    if (n == 4000) hang();
  endtask : wait_ch
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    m_mode = 0;
    m_flags = 0;
    {psel, penable, pwrite, rst_n} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    k = $urandom(36);
    ct0 = 8 + $urandom % 24;
    ct1 = 8 + $urandom % 24;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, MODE_BASE, 32'h0);
    chk(rd, m_mode);
    chk1(ready_n, 1'b1);
    $display("reset test done");
    // single conversion on channel 2, which is disabled
    apb(1'b1, CT_BASE + 8'h08, ct0);
    apb(1'b1, MODE_BASE + 8'h08, {MODE_SINGLE, 5'h0});
    wait_rdy();
    m_op(MODE_SINGLE, 2);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'hf, m_flags);
    apb(1'b0, MODE_BASE, 32'h0);
    chk(rd, m_mode);
    apb(1'b0, DATA_BASE + 8'h08, 32'h0);
    chk(rd, m_q.pop_front());
    m_flags = m_flags & ~(1 << 2);
    @(posedge clk);
    chk1(ready_n, m_flags == 0);
    $display("single test done");
    // continuous over channels 0 and 1
    apb(1'b1, ENABLE_OFS, 32'h3);
    apb(1'b1, CT_BASE, ct0);
    apb(1'b1, CT_BASE + 8'h04, ct1);
    apb(1'b1, MODE_BASE, {MODE_CONT, 5'h0});
    wait_ch(2'h1, k);
    wait_ch(2'h0, k);
    chk(k + 1, ct1);
    wait_ch(2'h1, k);
    chk(k + 1, ct0);
    m_flags = 3;
    m_q.push_back(lvl(0));
    m_q.push_back(lvl(1));
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'hf, m_flags);
    apb(1'b0, DATA_BASE, 32'h0);
    chk(rd, m_q.pop_front());
    apb(1'b0, DATA_BASE + 8'h04, 32'h0);
    chk(rd, m_q.pop_front());
    chk1(active, 1'b1);
    apb(1'b1, MODE_BASE, 32'h0);
    m_flags = 0;
    @(posedge clk);
    chk1(ready_n, m_flags == 0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'hf, m_flags);
    $display("continuous test done");
    // standby, then clock output disable in idle
    apb(1'b1, MODE_BASE, {MODE_STBY, 5'h0});
    repeat (2) @(posedge clk);
    chk1(cpd, 1'b1);
    chk1(bpd, 1'b1);
    chk1(clk_en, 1'b1);
    apb(1'b0, CT_BASE, 32'h0);
    chk(rd, ct0);
    apb(1'b1, MODE_BASE, 32'h10);
    repeat (2) @(posedge clk);
    chk1(clk_en, 1'b0);
    chk1(cpd, 1'b0);
    chk1(bpd, 1'b0);
    $display("standby test done");
    // every calibration on channel 1
    foreach (codes[j]) begin
      apb(1'b1, MODE_BASE + 8'h04, {codes[j], 5'h0});
      repeat (2) @(posedge clk);
      chk1(shorted, codes[j] == MODE_SELF_ZS);
      wait_rdy();
      m_op(codes[j], 1);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd & 32'hf, m_flags);
      apb(1'b0, MODE_BASE, 32'h0);
      chk(rd, m_mode);
      apb(1'b0, cal_addr[j], 32'h0);
      chk(rd, m_q.pop_front());
    end
    $display("calibration test done");
    apb(1'b0, 8'h08, 32'h0);
    chk1(err, 1'b1);
    apb(1'b0, MODE_BASE + 8'h04, 32'h0);
    chk1(err, 1'b1);
    $display("refusal test done");
    final_report();
  end
endmodule : adc_mode_sequencer_bench
bind adc_mode_sequencer adc_mode_sequencer_checker chk_u (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ready_n(ready_n), .core_power_down(core_power_down),
  .buffer_power_down(buffer_power_down), .inputs_shorted(inputs_shorted),
  .conv_active(conv_active), .master_clock_output_pin_en(master_clock_output_pin_en));
`default_nettype wire
